// ===== verilog/pdc_pkg.sv
// Purpose: shared constants for the port direction control block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, word registers
// Notes:   register byte address is four times its index

// ---------------------------------------------------------------------
// port direction control package
// ---------------------------------------------------------------------
package pdc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned BE_W   = 4;

  // port widths
  localparam int unsigned PORT0_W = 8;
  localparam int unsigned PORT1_W = 7;

  // register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_PORT0_DIR = 6'h08;
  localparam logic [IDX_W-1:0] IDX_PORT1_DIR = 6'h09;
  localparam logic [IDX_W-1:0] IDX_PORT0_OUT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_PORT1_OUT = 6'h11;
  localparam logic [IDX_W-1:0] IDX_PORT0_IN  = 6'h12;
  localparam logic [IDX_W-1:0] IDX_PORT1_IN  = 6'h13;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 6'h14;

  // field positions
  localparam int unsigned CTRL_RST_DIS_BIT = 0;
  localparam int unsigned RESET_PIN_BIT    = 6;

  // reset values
  localparam logic [DATA_W-1:0] RST_DIR0 = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_DIR1 = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_OUT0 = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_OUT1 = 32'h0000_0000;
  localparam logic              RST_CTRL = 1'b0;

endpackage

// ===== verilog/pdc_port_direction_control.sv
// Purpose: direction, output data and pullup control for ports 0 and 1
// Assumes: Avalon-MM master on i_ref_clk, pins asynchronous to the clock
// Notes:   one wait cycle per access; pin controls lag a write by a cycle
//
// Operation
// RQ1 - every reset clears both direction registers, all pins become inputs
// RQ2 - direction bit one drives its pin with the matching output data bit
// RQ3 - direction bit zero releases the pin so outside logic sets its level
// RQ4 - input pin: output data one enables weak pullup, zero leaves three-state
// RQ5 - each pin follows only its own direction bit, no coupling
// RQ6 - port 0 uses eight bits, port 1 seven, its top bit reads zero
// RQ7 - direction registers are freely readable and writable at any time
// RQ8 - port 1 bit 6 reset input stays active until reset-pin disable set
// RQ9 - while active, driving that pin low from the port causes reset
// RQ10 - port 1 input register returns present pin levels whatever direction
// RQ11 - pin controls update on the clock edge after a register write
//
// Our own choice: the Avalon-MM register port.

`timescale 1ns/1ps

module pdc_port_direction_control
  import pdc_pkg::*;
#(
  parameter int unsigned P0_W = pdc_pkg::PORT0_W,
  parameter int unsigned P1_W = pdc_pkg::PORT1_W
)
(
  // clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_arst_n,
  // avalon-mm slave
  input  wire logic [pdc_pkg::ADDR_W-1:0] i_address,
  input  wire logic                       i_read,
  input  wire logic                       i_write,
  input  wire logic [pdc_pkg::BE_W-1:0]   i_byteenable,
  input  wire logic [pdc_pkg::DATA_W-1:0] i_writedata,
  output logic      [pdc_pkg::DATA_W-1:0] o_readdata,
  output logic                            o_waitrequest,
  // port 0 pins
  input  wire logic [P0_W-1:0]            i_p0_pin,
  output logic      [P0_W-1:0]            o_p0_out,
  output logic      [P0_W-1:0]            o_p0_oe,
  output logic      [P0_W-1:0]            o_p0_pullup,
  // port 1 pins
  input  wire logic [P1_W-1:0]            i_p1_pin,
  output logic      [P1_W-1:0]            o_p1_out,
  output logic      [P1_W-1:0]            o_p1_oe,
  output logic      [P1_W-1:0]            o_p1_pullup,
  // reset request toward the system reset controller
  output logic                            o_reset_req
);

  import pdc_pkg::*;

  // -------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------

  // word index from a byte address
  function automatic logic [IDX_W-1:0] word_idx(
    input logic [ADDR_W-1:0] addr
  );
    word_idx = addr[ADDR_W-1:2];
  endfunction

  // true when the word index matches idx and the low address bits name a word boundary
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [IDX_W-1:0]  idx
  );
    hit = (word_idx(addr) == idx) && (addr[1:0] == 2'h0);
  endfunction

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------

  logic [P0_W-1:0] p0_meta_q;
  logic [P0_W-1:0] p0_sync_q;
  logic [P1_W-1:0] p1_meta_q;
  logic [P1_W-1:0] p1_sync_q;

  // two stages; only the second stage feeds any logic
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      p0_meta_q <= '0;
      p0_sync_q <= '0;
      // reset pin bit idles high: release must not raise a false request
      p1_meta_q <= P1_W'(1) << RESET_PIN_BIT;
      p1_sync_q <= P1_W'(1) << RESET_PIN_BIT;
    end
    else
    begin
      p0_meta_q <= i_p0_pin;
      p0_sync_q <= p0_meta_q;
      p1_meta_q <= i_p1_pin;
      p1_sync_q <= p1_meta_q; // RQ10
    end
  end

  // -------------------------------------------------------------------
  // register file and bus slave
  // -------------------------------------------------------------------

  logic [P0_W-1:0]   dir0_q;
  logic [P0_W-1:0]   dir0_d;
  logic [P1_W-1:0]   dir1_q;
  logic [P1_W-1:0]   dir1_d;
  logic [P0_W-1:0]   out0_q;
  logic [P0_W-1:0]   out0_d;
  logic [P1_W-1:0]   out1_q;
  logic [P1_W-1:0]   out1_d;
  logic              rst_dis_q;
  logic              rst_dis_d;
  logic              wait_q;
  logic              wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rword;
  logic              wr_lane0;

  // read mux; narrow registers sit low, upper bits read zero
  always_comb
  begin
    rword = '0;
    if (hit(i_address, IDX_PORT0_DIR))
      rword[P0_W-1:0] = dir0_q; // RQ7
    else if (hit(i_address, IDX_PORT1_DIR))
      rword[P1_W-1:0] = dir1_q; // RQ6
    else if (hit(i_address, IDX_PORT0_OUT))
      rword[P0_W-1:0] = out0_q;
    else if (hit(i_address, IDX_PORT1_OUT))
      rword[P1_W-1:0] = out1_q;
    else if (hit(i_address, IDX_PORT0_IN))
      rword[P0_W-1:0] = p0_sync_q;
    else if (hit(i_address, IDX_PORT1_IN))
      rword[P1_W-1:0] = p1_sync_q; // RQ10
    else if (hit(i_address, IDX_CTRL))
      rword[CTRL_RST_DIS_BIT] = rst_dis_q;
  end

  // byte lane 0 carries every register field
  assign wr_lane0 = i_write && i_byteenable[0];

  // first cycle latches read data, second cycle completes the access
  always_comb
  begin
    wait_d    = wait_q;
    rdata_d   = rdata_q;
    dir0_d    = dir0_q;
    dir1_d    = dir1_q;
    out0_d    = out0_q;
    out1_d    = out1_q;
    rst_dis_d = rst_dis_q;
    if (wait_q)
    begin
      if (i_read || i_write)
      begin
        wait_d = 1'b0;
        if (i_read)
          rdata_d = rword;
      end
    end
    else
    begin
      // write lands at the edge where waitrequest is seen low
      wait_d = 1'b1;
      if (wr_lane0)
      begin
        if (hit(i_address, IDX_PORT0_DIR))
          dir0_d = i_writedata[P0_W-1:0]; // RQ7
        if (hit(i_address, IDX_PORT1_DIR))
          dir1_d = i_writedata[P1_W-1:0]; // RQ6
        if (hit(i_address, IDX_PORT0_OUT))
          out0_d = i_writedata[P0_W-1:0];
        if (hit(i_address, IDX_PORT1_OUT))
          out1_d = i_writedata[P1_W-1:0];
        if (hit(i_address, IDX_CTRL))
          rst_dis_d = i_writedata[CTRL_RST_DIS_BIT]; // RQ8
      end
    end
  end

  // waitrequest idles high so no access completes without a latch cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wait_q    <= 1'b1;
      rdata_q   <= '0;
      dir0_q    <= RST_DIR0[P0_W-1:0]; // RQ1
      dir1_q    <= RST_DIR1[P1_W-1:0]; // RQ1
      out0_q    <= RST_OUT0[P0_W-1:0];
      out1_q    <= RST_OUT1[P1_W-1:0];
      rst_dis_q <= RST_CTRL;
    end
    else
    begin
      wait_q    <= wait_d;
      rdata_q   <= rdata_d;
      dir0_q    <= dir0_d;
      dir1_q    <= dir1_d;
      out0_q    <= out0_d;
      out1_q    <= out1_d;
      rst_dis_q <= rst_dis_d;
    end
  end

  assign o_waitrequest = wait_q;
  assign o_readdata    = rdata_q;

  // -------------------------------------------------------------------
  // pin drivers
  // -------------------------------------------------------------------

  logic [P0_W-1:0] p0_out_q;
  logic [P0_W-1:0] p0_oe_q;
  logic [P0_W-1:0] p0_pu_q;
  logic [P1_W-1:0] p1_out_q;
  logic [P1_W-1:0] p1_oe_q;
  logic [P1_W-1:0] p1_pu_q;
  logic [P0_W-1:0] p0_oe_d;
  logic [P0_W-1:0] p0_pu_d;
  logic [P1_W-1:0] p1_oe_d;
  logic [P1_W-1:0] p1_pu_d;

  // one slice per pin keeps every pin on its own bit only
  for (genvar g = 0; g < P0_W; g++)
  begin : g_p0
    always_comb
    begin
      p0_oe_d[g] = dir0_q[g];              // RQ2 RQ3 RQ5
      p0_pu_d[g] = !dir0_q[g] && out0_q[g]; // RQ4
    end
  end

  for (genvar g = 0; g < P1_W; g++)
  begin : g_p1
    always_comb
    begin
      p1_oe_d[g] = dir1_q[g];              // RQ2 RQ3 RQ5
      p1_pu_d[g] = !dir1_q[g] && out1_q[g]; // RQ4
    end
  end

  // registered stage keeps outputs glitch free, costs one cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      p0_out_q <= RST_OUT0[P0_W-1:0];
      p0_oe_q  <= '0; // RQ1
      p0_pu_q  <= '0;
      p1_out_q <= RST_OUT1[P1_W-1:0];
      p1_oe_q  <= '0; // RQ1
      p1_pu_q  <= '0;
    end
    else
    begin
      p0_out_q <= out0_q; // RQ2 RQ11
      p0_oe_q  <= p0_oe_d; // RQ11
      p0_pu_q  <= p0_pu_d; // RQ11
      p1_out_q <= out1_q; // RQ2 RQ11
      p1_oe_q  <= p1_oe_d; // RQ11
      p1_pu_q  <= p1_pu_d; // RQ11
    end
  end

  assign o_p0_out    = p0_out_q;
  assign o_p0_oe     = p0_oe_q;
  assign o_p0_pullup = p0_pu_q;
  assign o_p1_out    = p1_out_q;
  assign o_p1_oe     = p1_oe_q;
  assign o_p1_pullup = p1_pu_q;

  // -------------------------------------------------------------------
  // reset input on port 1 bit 6
  // -------------------------------------------------------------------

  logic self_low;
  logic rst_req_d;
  logic rst_req_q;

  // own drive is checked directly so a reset needs no pin loopback
  always_comb
  begin
    self_low  = dir1_q[RESET_PIN_BIT] && !out1_q[RESET_PIN_BIT]; // RQ9
    rst_req_d = !rst_dis_q &&
                (self_low || !p1_sync_q[RESET_PIN_BIT]); // RQ8 RQ9
  end

  // request only; the system reset controller decides what it clears
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_req_q <= 1'b0;
    else
      rst_req_q <= rst_req_d;
  end

  assign o_reset_req = rst_req_q;

endmodule

// ===== verif/pdc_sva.sv
// Purpose: port-level checks for the port direction control block
// Assumes: sees only the top ports; registers inferred from bus writes
// Notes:   pin controls lag an accepted write by two edges
`timescale 1ns/1ps
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module pdc_sva
  import pdc_pkg::*;
#(
  parameter int unsigned P0_W = 8,
  parameter int unsigned P1_W = 7
)
(
  // clock, reset and bus
  input wire logic                       i_ref_clk,
  input wire logic                       i_arst_n,
  input wire logic [pdc_pkg::ADDR_W-1:0] i_address,
  input wire logic                       i_read,
  input wire logic                       i_write,
  input wire logic [pdc_pkg::BE_W-1:0]   i_byteenable,
  input wire logic [pdc_pkg::DATA_W-1:0] i_writedata,
  input wire logic [pdc_pkg::DATA_W-1:0] o_readdata,
  input wire logic                       o_waitrequest,
  // pin controls
  input wire logic [P0_W-1:0]            o_p0_out,
  input wire logic [P0_W-1:0]            o_p0_oe,
  input wire logic [P0_W-1:0]            o_p0_pullup,
  input wire logic [P1_W-1:0]            o_p1_out,
  input wire logic [P1_W-1:0]            o_p1_oe,
  input wire logic [P1_W-1:0]            o_p1_pullup
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // access completes where waitrequest is sampled low
  sequence s_done(a);
    (i_read || i_write) && !o_waitrequest && i_address == a;
  endsequence
  sequence s_dwr(a);
    s_done(a) ##0 (i_write && i_byteenable[0]);
  endsequence
  // pullup is on only for an input pin with output data one
  a_pullup_p0: assert property (o_p0_pullup == (~o_p0_oe & o_p0_out))
    else $error("port0 pullup wrong");
  a_pullup_p1: assert property (o_p1_pullup == (~o_p1_oe & o_p1_out))
    else $error("port1 pullup wrong");
  a_wait_one: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_answer_time: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("access not answered");
  a_reset_clear: assert property ($rose(i_arst_n)
    |-> o_p0_oe == '0 && o_p1_oe == '0) else $error("oe not clear");
  a_dir0_write: assert property (s_dwr(8'h20)
    |-> ##2 o_p0_oe == $past(i_writedata[P0_W-1:0], 2))
    else $error("port0 oe not updated");
  a_dir1_write: assert property (s_dwr(8'h24)
    |-> ##2 o_p1_oe == $past(i_writedata[P1_W-1:0], 2))
    else $error("port1 oe not updated");
  a_dir1_top: assert property (s_done(8'h24) ##0 i_read
    |-> o_readdata[DATA_W-1:P1_W] == '0) else $error("reserved bit set");
  a_oe_cause: assert property ($changed({o_p0_oe, o_p1_oe})
    |-> $past(i_write && !o_waitrequest, 2)) else $error("oe moved alone");
endmodule

bind pdc_port_direction_control pdc_sva #(.P0_W(P0_W), .P1_W(P1_W)) u_sva
  (.i_ref_clk, .i_arst_n, .i_address, .i_read, .i_write, .i_byteenable,
   .i_writedata, .o_readdata, .o_waitrequest, .o_p0_out, .o_p0_oe,
   .o_p0_pullup, .o_p1_out, .o_p1_oe, .o_p1_pullup);

// ===== verif/pdc_port_direction_control_tb.sv
// Purpose: self-checking bench for the port direction control block
// Assumes: one wait cycle per access, pins synchronised in two flops
// Notes:   port1 bit6 held high unless a scenario pulls it low
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module pdc_port_direction_control_tb;
  import pdc_pkg::*;
  localparam logic [7:0] A_DIR0 = {IDX_PORT0_DIR, 2'b00};
  localparam logic [7:0] A_DIR1 = {IDX_PORT1_DIR, 2'b00};
  localparam logic [7:0] A_OUT0 = {IDX_PORT0_OUT, 2'b00};
  localparam logic [7:0] A_OUT1 = {IDX_PORT1_OUT, 2'b00};
  localparam logic [7:0] A_IN0  = {IDX_PORT0_IN, 2'b00};
  localparam logic [7:0] A_IN1  = {IDX_PORT1_IN, 2'b00};
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  logic        i_ref_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  i_address = 8'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [3:0]  i_byteenable = 4'hF;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic [7:0]  i_p0_pin = 8'h00;
  logic [7:0]  o_p0_out, o_p0_oe, o_p0_pullup;
  logic [6:0]  i_p1_pin = 7'h7F;
  logic [6:0]  o_p1_out, o_p1_oe, o_p1_pullup;
  logic        o_reset_req;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // 100 ns period clock
  always #50 i_ref_clk = ~i_ref_clk;
  pdc_port_direction_control u_dut (.i_ref_clk, .i_arst_n, .i_address,
    .i_read, .i_write, .i_byteenable, .i_writedata, .o_readdata,
    .o_waitrequest, .i_p0_pin, .o_p0_out, .o_p0_oe, .o_p0_pullup,
    .i_p1_pin, .o_p1_out, .o_p1_oe, .o_p1_pullup, .o_reset_req);
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge i_ref_clk); // requests start right after a rising edge
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= d;
    do
    begin
      @(posedge i_ref_clk);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      end_sim();
    end
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_ref_clk); // no strobe reassigned in the same step
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // lets registered pin controls land before looking
  task automatic gap(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic t_port0();
    wr(A_OUT0, 32'hA5);
    wr(A_DIR0, 32'h0F);
    gap(1);
    `CHK(o_p0_oe, 8'h0F)
    `CHK(o_p0_out, 8'hA5)
    `CHK(o_p0_pullup, 8'hA0)
    for (int i = 0; i < 8; i++)
    begin
      wr(A_DIR0, 32'h1 << i);
      gap(1);
      `CHK(o_p0_oe, 8'h01 << i)
    end
    rd_chk(A_DIR0, 32'h80);
  endtask
  task automatic t_port1();
    wr(A_OUT1, 32'h7F);
    wr(A_DIR1, 32'hFF);
    rd_chk(A_DIR1, 32'h7F);
    i_p1_pin <= 7'h55;
    i_p0_pin <= 8'h3C;
    gap(1);
    `CHK(o_p1_oe, 7'h7F)
    `CHK(o_p1_out, 7'h7F)
    `CHK(o_p1_pullup, 7'h00)
    gap(4);
    rd_chk(A_IN1, 32'h55);
    wr(A_DIR1, 32'h00);
    gap(1);
    `CHK(o_p1_pullup, 7'h7F)
    rd_chk(A_IN1, 32'h55);
    rd_chk(A_IN0, 32'h3C);
  endtask
  // port1 bit6 reset function, from the port and from the pin
  task automatic t_reset_pin();
    wr(A_OUT1, 32'h3F);
    wr(A_DIR1, 32'h40);
    gap(1);
    `CHK(o_reset_req, 1'b1)
    wr(A_CTRL, 32'h1);
    i_p1_pin <= 7'h15;
    gap(1);
    `CHK(o_reset_req, 1'b0)
    gap(4);
    `CHK(o_reset_req, 1'b0)
    wr(A_CTRL, 32'h0);
    gap(1);
    `CHK(o_reset_req, 1'b1)
    // own drive released: the low pin alone must still request
    wr(A_DIR1, 32'h00);
    gap(4);
    `CHK(o_reset_req, 1'b1)
    wr(A_OUT1, 32'h7F);
    i_p1_pin <= 7'h55;
    gap(4);
    `CHK(o_reset_req, 1'b0)
  endtask
  // refused accesses leave the direction register alone
  task automatic t_refuse();
    rd_chk(8'h7C, 32'h0);
    wr(8'h21, 32'hFF);
    i_byteenable <= 4'hE;
    wr(A_DIR0, 32'hFF);
    i_byteenable <= 4'hF;
    rd_chk(A_DIR0, 32'h80);
  endtask
  task automatic t_midreset();
    wr(A_DIR0, 32'hFF);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    gap(1);
    `CHK(o_p0_oe, 8'h00)
    `CHK(o_reset_req, 1'b0)
    rd_chk(A_DIR0, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    gap(1);
    `CHK(o_p1_oe, 7'h00)
    `CHK(o_reset_req, 1'b0)
    rd_chk(A_DIR1, 32'h0);
    t_port0();
    t_port1();
    t_reset_pin();
    t_refuse();
    t_midreset();
    end_sim();
  end
endmodule
